// ===== mtis_defs.svh
// constants of the measure timer input select and status block
// assumes one 10 mhz core clock and a 16-bit axi4-lite byte address
`ifndef MTIS_DEFS_SVH
`define MTIS_DEFS_SVH
// -----------------------------------------------------------------
// register indexes (byte address = index * 4)
// -----------------------------------------------------------------
`define MTIS_IDX_STAT_B 14'h0f06
`define MTIS_IDX_CLK_B 14'h0f07
`define MTIS_IDX_SIG_B 14'h0f08
`define MTIS_IDX_WIN_B 14'h0f09
`define MTIS_IDX_CTL_B 14'h0f0a
`define MTIS_IDX_STAT_A 14'h0f18
`define MTIS_IDX_CLK_A 14'h0f19
`define MTIS_IDX_SIG_A 14'h0f1a
`define MTIS_IDX_WIN_A 14'h0f1b
`define MTIS_IDX_CTL_A 14'h0f1c
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define MTIS_ST_PER 7
`define MTIS_ST_WID 6
`define MTIS_ST_CLR 4
`define MTIS_ST_CNT 2
`define MTIS_ST_WIN 1
`define MTIS_ST_ACQ 0
`define MTIS_CT_GO 7
`define MTIS_CT_GINV 4
`define MTIS_CT_MINV 3
`define MTIS_CK_LF 3
`define MTIS_CK_MF16 5
`define MTIS_CK_SECONDARY_OSC 6
// -----------------------------------------------------------------
// widths, counts and reset values
// -----------------------------------------------------------------
`define MTIS_CLK_NUM 4'h8
`define MTIS_SIG_NUM 5'h17
`define MTIS_WIN_NUM 5'h16
`define MTIS_SEL_RST 5'h00
`define MTIS_CLK_RST 3'h0
`define MTIS_RESP_OKAY 2'h0
`define MTIS_RESP_SLVERR 2'h2
`endif

// ===== mtis_pkg.sv
// types shared by the measure timer input select and status block
// assumes mtis_defs.svh is compiled alongside
package mtis_pkg;
  // sources that feed the three selectors, all from other domains
  typedef struct packed {
    logic [7:0] clk_src;
    logic [8:0] tmr;
    logic [4:0] ccp;
    logic [1:0] pwm;
    logic [2:0] cmp;
    logic zcd;
    logic [1:0] meas_pin;
    logic [1:0] gate_pin;
    logic [1:0] ovf;
  } mtis_src_t;
  // software settings of one instance
  typedef struct packed {
    logic go;
    logic gate_inv;
    logic meas_inv;
    logic [2:0] clk_sel;
    logic [4:0] sig_sel;
    logic [4:0] win_sel;
  } mtis_cfg_t;
endpackage : mtis_pkg

// ===== mtis_top.sv
// input selection and status of two 24-bit measurement timers (a and b)
// assumes the counter, capture buffers and edge logic sit outside on core_clk_i
//
// Operation
// RQ1: writing one to status bit 7 raises a period buffer refresh request that reads one until done.
// RQ2: writing one to status bit 6 raises a width buffer refresh request that reads one until done.
// RQ3: writing one to status bit 4 requests a counter clear and reads zero once it is carried out.
// RQ4: read-only status bit 2 shows whether the counter is incrementing, following go.
// RQ5: read-only status bit 1 shows whether the measurement window is open.
// RQ6: read-only status bit 0 shows whether an acquisition is in progress.
// RQ7: a 3-bit clock select picks one of eight counting clock sources in the listed order.
// RQ8: signal select code 0 is the routed pin, 1 to 9 are timers 0 to 8, and the cross overflow code differs per instance.
// RQ9: signal select codes 12 to 22 are capture units, pulse generators, comparators and zero cross; above is reserved.
// RQ10: window select code 0 is the pin, 1 to 3 oscillators, 4 to 8 even timers, cross overflow per instance.
// RQ11: window select codes 11 to 21 are capture units, pulse generators, comparators and zero cross; above is reserved.
// RQ12: polarity bits invert the selected window and signal so that active low becomes active high.
// RQ13: the go bit enables incrementing and acquisition and the counting flag follows it.
// RQ14: a reserved select code feeds a constant inactive level onward.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "mtis_defs.svh"
module mtis_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire mtis_pkg::mtis_src_t src_i,
  input wire logic [1:0] period_refresh_done_i,
  input wire logic [1:0] width_refresh_done_i,
  input wire logic [1:0] counter_clear_done_i,
  output logic [1:0] period_buffer_refresh_req_o,
  output logic [1:0] width_buffer_refresh_req_o,
  output logic [1:0] counter_clear_req_o,
  output logic [1:0] go_o,
  output logic [1:0] count_clock_o,
  output logic [1:0] measured_o,
  output logic [1:0] gate_o
);

  // -----------------------------------------------------------------
  // source synchroniser
  // -----------------------------------------------------------------
  mtis_pkg::mtis_src_t src_meta_r;
  mtis_pkg::mtis_src_t src_r;

  // two stages; only src_r is read by the selectors
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      src_meta_r <= '0;
      src_r <= '0;
    end
    else
    begin
      src_meta_r <= src_i;
      src_r <= src_meta_r;
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite write channel
  // -----------------------------------------------------------------
  logic aw_have_r;
  logic w_have_r;
  logic [13:0] wr_idx_r;
  logic [7:0] wr_byte_r;
  logic wr_lane_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wr_hit;

  assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;

  // address and data are taken in either order, answer follows both
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_idx_r <= '0;
      wr_byte_r <= '0;
      wr_lane_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `MTIS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_r)
      begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        wr_idx_r <= s_axi_awaddr_i[15:2];
      end
      if (s_axi_wvalid_i && wready_r)
      begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wr_byte_r <= s_axi_wdata_i[7:0];
        wr_lane_r <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `MTIS_RESP_OKAY : `MTIS_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // -----------------------------------------------------------------
  // per instance registers and selectors
  // -----------------------------------------------------------------
  mtis_pkg::mtis_cfg_t cfg_r [2];
  logic [7:0] stat_w [2];
  logic [1:0] hit_w;
  logic [1:0] per_req_r;
  logic [1:0] wid_req_r;
  logic [1:0] clr_req_r;
  logic [1:0] counting_r;
  logic [1:0] window_r;
  logic [1:0] acquiring_r;
  logic [1:0] cclk_r;
  logic [1:0] meas_r;
  logic [1:0] gate_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_inst
      // instance 0 is a, instance 1 is b
      localparam logic [13:0] IdxStat = (gi == 0) ? `MTIS_IDX_STAT_A : `MTIS_IDX_STAT_B;
      localparam logic [13:0] IdxClk = (gi == 0) ? `MTIS_IDX_CLK_A : `MTIS_IDX_CLK_B;
      localparam logic [13:0] IdxSig = (gi == 0) ? `MTIS_IDX_SIG_A : `MTIS_IDX_SIG_B;
      localparam logic [13:0] IdxWin = (gi == 0) ? `MTIS_IDX_WIN_A : `MTIS_IDX_WIN_B;
      localparam logic [13:0] IdxCtl = (gi == 0) ? `MTIS_IDX_CTL_A : `MTIS_IDX_CTL_B;
      logic wr_stat;
      logic [22:0] sig_vec;
      logic [21:0] win_vec;
      logic ovf_other;
      logic sig_lvl;
      logic win_lvl;
      logic clk_lvl;

      assign hit_w[gi] = (wr_idx_r == IdxStat) | (wr_idx_r == IdxClk) | (wr_idx_r == IdxSig)
                         | (wr_idx_r == IdxWin) | (wr_idx_r == IdxCtl);
      assign wr_stat = wr_fire & wr_lane_r & (wr_idx_r == IdxStat);

      // settings; a write without the low byte lane is ignored
      always_ff @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          cfg_r[gi] <= '{go: 1'b0, gate_inv: 1'b0, meas_inv: 1'b0, clk_sel: `MTIS_CLK_RST,
                         sig_sel: `MTIS_SEL_RST, win_sel: `MTIS_SEL_RST};
        end
        else if (wr_fire && wr_lane_r)
        begin
          if (wr_idx_r == IdxClk)
            cfg_r[gi].clk_sel <= wr_byte_r[2:0];
          if (wr_idx_r == IdxSig)
            cfg_r[gi].sig_sel <= wr_byte_r[4:0];
          if (wr_idx_r == IdxWin)
            cfg_r[gi].win_sel <= wr_byte_r[4:0];
          if (wr_idx_r == IdxCtl)
          begin
            cfg_r[gi].go <= wr_byte_r[`MTIS_CT_GO]; // RQ13
            cfg_r[gi].gate_inv <= wr_byte_r[`MTIS_CT_GINV]; // RQ12
            cfg_r[gi].meas_inv <= wr_byte_r[`MTIS_CT_MINV]; // RQ12
          end
        end
      end

      // manual requests: a new write of one wins over a done in the same cycle
      always_ff @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          per_req_r[gi] <= 1'b0;
          wid_req_r[gi] <= 1'b0;
          clr_req_r[gi] <= 1'b0;
        end
        else
        begin
          if (wr_stat && wr_byte_r[`MTIS_ST_PER])
            per_req_r[gi] <= 1'b1; // RQ1
          else if (period_refresh_done_i[gi])
            per_req_r[gi] <= 1'b0; // RQ1
          if (wr_stat && wr_byte_r[`MTIS_ST_WID])
            wid_req_r[gi] <= 1'b1; // RQ2
          else if (width_refresh_done_i[gi])
            wid_req_r[gi] <= 1'b0; // RQ2
          if (wr_stat && wr_byte_r[`MTIS_ST_CLR])
            clr_req_r[gi] <= 1'b1; // RQ3
          else if (counter_clear_done_i[gi])
            clr_req_r[gi] <= 1'b0; // RQ3
        end
      end

      // the other instance's overflow takes a different code in a and b
      assign ovf_other = src_r.ovf[1 - gi];
      assign sig_vec = {src_r.zcd, src_r.cmp, src_r.pwm, src_r.ccp, // RQ9
                        (gi == 0) ? ovf_other : 1'b0, (gi == 0) ? 1'b0 : ovf_other, // RQ8
                        src_r.tmr, src_r.meas_pin[gi]}; // RQ8
      assign win_vec = {src_r.zcd, src_r.cmp, src_r.pwm, src_r.ccp, // RQ11
                        (gi == 0) ? ovf_other : 1'b0, (gi == 0) ? 1'b0 : ovf_other, // RQ10
                        src_r.tmr[8], src_r.tmr[6], src_r.tmr[4], src_r.tmr[2], src_r.tmr[0],
                        src_r.clk_src[`MTIS_CK_SECONDARY_OSC], src_r.clk_src[`MTIS_CK_MF16],
                        src_r.clk_src[`MTIS_CK_LF], src_r.gate_pin[gi]}; // RQ10

      // reserved codes give a constant inactive level after polarity
      assign sig_lvl = (cfg_r[gi].sig_sel < `MTIS_SIG_NUM) ?
                       (sig_vec[cfg_r[gi].sig_sel] ^ cfg_r[gi].meas_inv) : 1'b0; // RQ14 RQ12
      assign win_lvl = (cfg_r[gi].win_sel < `MTIS_WIN_NUM) ?
                       (win_vec[cfg_r[gi].win_sel] ^ cfg_r[gi].gate_inv) : 1'b0; // RQ14 RQ12
      assign clk_lvl = src_r.clk_src[cfg_r[gi].clk_sel]; // RQ7

      // selected levels and status flags, registered so outputs come from flops
      always_ff @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          cclk_r[gi] <= 1'b0;
          meas_r[gi] <= 1'b0;
          gate_r[gi] <= 1'b0;
          counting_r[gi] <= 1'b0;
          window_r[gi] <= 1'b0;
          acquiring_r[gi] <= 1'b0;
        end
        else
        begin
          cclk_r[gi] <= clk_lvl; // RQ7
          meas_r[gi] <= sig_lvl;
          gate_r[gi] <= win_lvl;
          counting_r[gi] <= cfg_r[gi].go; // RQ4 RQ13
          window_r[gi] <= win_lvl; // RQ5
          acquiring_r[gi] <= cfg_r[gi].go & sig_lvl; // RQ6 RQ13
        end
      end

      // status image; unused bits read zero
      always_comb
      begin
        stat_w[gi] = '0;
        stat_w[gi][`MTIS_ST_PER] = per_req_r[gi]; // RQ1
        stat_w[gi][`MTIS_ST_WID] = wid_req_r[gi]; // RQ2
        stat_w[gi][`MTIS_ST_CLR] = clr_req_r[gi]; // RQ3
        stat_w[gi][`MTIS_ST_CNT] = counting_r[gi]; // RQ4
        stat_w[gi][`MTIS_ST_WIN] = window_r[gi]; // RQ5
        stat_w[gi][`MTIS_ST_ACQ] = acquiring_r[gi]; // RQ6
      end
    end
  endgenerate

  assign wr_hit = |hit_w;

  // -----------------------------------------------------------------
  // axi4-lite read channel
  // -----------------------------------------------------------------
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_byte;
  logic rd_hit;

  // read decode; status reads have no side effect
  always_comb
  begin
    rd_byte = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i[15:2])
      `MTIS_IDX_STAT_A: rd_byte = stat_w[0];
      `MTIS_IDX_CLK_A: rd_byte = {5'h00, cfg_r[0].clk_sel};
      `MTIS_IDX_SIG_A: rd_byte = {3'h0, cfg_r[0].sig_sel};
      `MTIS_IDX_WIN_A: rd_byte = {3'h0, cfg_r[0].win_sel};
      `MTIS_IDX_CTL_A: rd_byte = {cfg_r[0].go, 2'h0, cfg_r[0].gate_inv, cfg_r[0].meas_inv, 3'h0};
      `MTIS_IDX_STAT_B: rd_byte = stat_w[1];
      `MTIS_IDX_CLK_B: rd_byte = {5'h00, cfg_r[1].clk_sel};
      `MTIS_IDX_SIG_B: rd_byte = {3'h0, cfg_r[1].sig_sel};
      `MTIS_IDX_WIN_B: rd_byte = {3'h0, cfg_r[1].win_sel};
      `MTIS_IDX_CTL_B: rd_byte = {cfg_r[1].go, 2'h0, cfg_r[1].gate_inv, cfg_r[1].meas_inv, 3'h0};
      default: rd_hit = 1'b0;
    endcase
  end

  // one read at a time; data answer one edge after the address is taken
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `MTIS_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? `MTIS_RESP_OKAY : `MTIS_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // -----------------------------------------------------------------
  // outputs to the counter and capture logic
  // -----------------------------------------------------------------
  assign period_buffer_refresh_req_o = per_req_r;
  assign width_buffer_refresh_req_o = wid_req_r;
  assign counter_clear_req_o = clr_req_r;
  assign go_o = {cfg_r[1].go, cfg_r[0].go};
  assign count_clock_o = cclk_r;
  assign measured_o = meas_r;
  assign gate_o = gate_r;

endmodule : mtis_top

// ===== mtis_monitor.sv
// checker: axi4-lite handshake timing and request flag relations of mtis_top
// assumes one core clock domain with an active-low asynchronous reset
`timescale 1ns/1ps
module mtis_monitor (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] period_refresh_done_i,
  input wire logic [1:0] width_refresh_done_i,
  input wire logic [1:0] counter_clear_done_i,
  input wire logic [1:0] period_buffer_refresh_req_o,
  input wire logic [1:0] width_buffer_refresh_req_o,
  input wire logic [1:0] counter_clear_req_o,
  input wire logic [1:0] go_o
);
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // write answer needs one edge to pair address and data, then one to raise bvalid
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o) else $error("write response late");
  // read answer comes one edge after the address is taken
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  // a stalled master must see the write answer unchanged and rvalid still high
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("read data dropped");
  // period and clear flags of a and the width flag of b clear only through a done pulse from the unit
  a_period_hold: assert property (period_buffer_refresh_req_o[0] && !period_refresh_done_i[0]
    |=> period_buffer_refresh_req_o[0]) else $error("period request lost");
  a_width_hold: assert property (width_buffer_refresh_req_o[1] && !width_refresh_done_i[1]
    |=> width_buffer_refresh_req_o[1]) else $error("width request lost");
  a_clear_drop: assert property ($fell(counter_clear_req_o[0]) |-> $past(counter_clear_done_i[0]))
    else $error("clear request dropped early");
  a_go_change: assert property ($changed(go_o) |-> $rose(s_axi_bvalid_o))
    else $error("go moved without a write");
endmodule : mtis_monitor
bind mtis_top mtis_monitor u_mtis_monitor (
  .core_clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .period_refresh_done_i, .width_refresh_done_i,
  .counter_clear_done_i, .period_buffer_refresh_req_o, .width_buffer_refresh_req_o,
  .counter_clear_req_o, .go_o
);

// ===== mtis_unit_model.sv
// far-side model: answers refresh and clear requests with one-cycle done pulses
// assumes request levels on the core clock and dly_i held steady per request
`timescale 1ns/1ps
module mtis_unit_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] dly_i,
  input wire logic [5:0] req_i,
  output logic [5:0] done_o
);
  logic [7:0] cnt_r [6];
  // a large dly_i keeps a request pending long enough to be read back
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    for (int k = 0; k < 6; k++)
    begin
      if (!rstn_i || !req_i[k] || done_o[k])
      begin
        cnt_r[k] <= 8'h00;
        done_o[k] <= 1'b0;
      end
      else
      begin
        cnt_r[k] <= cnt_r[k] + 8'h01;
        done_o[k] <= (cnt_r[k] == dly_i);
      end
    end
  end
endmodule : mtis_unit_model

// ===== tb_top.sv
// testbench: register, request and selector tests of mtis_top over axi4-lite
// assumes mtis_pkg, mtis_top, mtis_unit_model and mtis_monitor compiled first
`timescale 1ns/1ps
`include "mtis_defs.svh"
module tb_top;
  logic clk, rstn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, go, cclk, meas, gate;
  wire [5:0] reqs;
  wire [5:0] dones;
  logic [7:0] dly;
  mtis_pkg::mtis_src_t src, s;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [7:0] ctl_set [4] = '{8'h98, 8'h80, 8'h18, 8'h08};
  mtis_top u_mtis_top (
    .core_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .src_i(src),
    .period_refresh_done_i(dones[1:0]), .width_refresh_done_i(dones[3:2]), .counter_clear_done_i(dones[5:4]),
    .period_buffer_refresh_req_o(reqs[1:0]), .width_buffer_refresh_req_o(reqs[3:2]),
    .counter_clear_req_o(reqs[5:4]), .go_o(go), .count_clock_o(cclk), .measured_o(meas), .gate_o(gate)
  );
  mtis_unit_model u_mtis_unit_model (.clk_i(clk), .rstn_i(rstn), .dly_i(dly), .req_i(reqs), .done_o(dones));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------------------
  // bus tasks and comparisons
  // ------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask : chk_pin
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    {awv, wv, bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    while (!bv);
    bready <= 1'b0;
    chk_reg("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axi_wr
  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    {arv, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rready <= 1'b0;
    chk_reg("rdata", {24'h000000, e}, rdata);
    chk_reg("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk
  function automatic logic [13:0] base(input int i);
    return i ? `MTIS_IDX_STAT_B : `MTIS_IDX_STAT_A;
  endfunction : base
  // one-hot source that a code should route; reserved codes route nothing
  function automatic mtis_pkg::mtis_src_t pick(input int kd, input int c, input int i);
    mtis_pkg::mtis_src_t p;
    p = '0;
    if (kd == 0) p.clk_src[c] = 1'b1;
    else if (c == 0 && kd == 1) p.meas_pin[i] = 1'b1;
    else if (c == 0) p.gate_pin[i] = 1'b1;
    else if (kd == 1)
    begin
      if (c <= 9) p.tmr[c - 1] = 1'b1;
      else if (c == 11 - i) p.ovf[1 - i] = 1'b1;
      else if (c >= 12 && c <= 16) p.ccp[c - 12] = 1'b1;
      else if (c == 17 || c == 18) p.pwm[c - 17] = 1'b1;
      else if (c >= 19 && c <= 21) p.cmp[c - 19] = 1'b1;
      else if (c == 22) p.zcd = 1'b1;
    end
    else
    begin
      if (c <= 3) p.clk_src[c == 1 ? 3 : c == 2 ? 5 : 6] = 1'b1;
      else if (c <= 8) p.tmr[2 * (c - 4)] = 1'b1;
      else if (c == 10 - i) p.ovf[1 - i] = 1'b1;
      else if (c >= 11 && c <= 15) p.ccp[c - 11] = 1'b1;
      else if (c == 16 || c == 17) p.pwm[c - 16] = 1'b1;
      else if (c >= 18 && c <= 20) p.cmp[c - 18] = 1'b1;
      else if (c == 21) p.zcd = 1'b1;
    end
    return p;
  endfunction : pick
  function automatic logic sel(input int kd, input int i);
    return kd == 0 ? cclk[i] : kd == 1 ? meas[i] : gate[i];
  endfunction : sel
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // hang guard: the full run needs under 10000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    {awv, wv, bready, arv, rready} = 5'h00;
    {awaddr, araddr, wdata} = 64'h0;
    src = '0;
    dly = 8'h14;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 2; i++)
      for (int o = 0; o < 5; o++) rd_chk(base(i) + 14'(o), 8'h00, `MTIS_RESP_OKAY);
    rd_chk(14'h0f0b, 8'h00, `MTIS_RESP_SLVERR);
    axi_wr(14'h0f0b, 8'hff, `MTIS_RESP_SLVERR);
    // requests stay pending until the unit answers; the flags are read-only
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(base(i), 8'h07, `MTIS_RESP_OKAY);
      rd_chk(base(i), 8'h00, `MTIS_RESP_OKAY);
      dly <= i ? 8'h00 : 8'h14;
      for (int k = 0; k < 3; k++)
      begin
        axi_wr(base(i), 8'h01 << (k == 0 ? `MTIS_ST_PER : k == 1 ? `MTIS_ST_WID : `MTIS_ST_CLR), `MTIS_RESP_OKAY);
        chk_pin("req", 1'b1, reqs[2 * k + i]);
        if (i == 0) rd_chk(base(i), 8'h01 << (k == 0 ? 7 : k == 1 ? 6 : 4), `MTIS_RESP_OKAY);
        while (|reqs) @(posedge clk);
        rd_chk(base(i), 8'h00, `MTIS_RESP_OKAY);
      end
    end
    // every select code routes its own source and nothing else
    for (int i = 0; i < 2; i++)
      for (int kd = 0; kd < 3; kd++)
        for (int c = 0; c < (kd ? 32 : 8); c++)
        begin
          s = pick(kd, c, i);
          axi_wr(base(i) + 14'(kd + 1), 8'(c), `MTIS_RESP_OKAY);
          rd_chk(base(i) + 14'(kd + 1), 8'(c), `MTIS_RESP_OKAY);
          src <= s;
          repeat (4) @(posedge clk);
          chk_pin("sel_on", |s, sel(kd, i));
          src <= ~s;
          repeat (4) @(posedge clk);
          chk_pin("sel_off", 1'b0, sel(kd, i));
        end
    // polarity, go and the three status flags, with both pins low
    src <= '0;
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(base(i) + 14'h0002, 8'h00, `MTIS_RESP_OKAY);
      axi_wr(base(i) + 14'h0003, 8'h00, `MTIS_RESP_OKAY);
      foreach (ctl_set[j])
      begin
        axi_wr(base(i) + 14'h0004, ctl_set[j], `MTIS_RESP_OKAY);
        repeat (4) @(posedge clk);
        chk_pin("go", ctl_set[j][7], go[i]);
        chk_pin("gate", ctl_set[j][4], gate[i]);
        chk_pin("meas", ctl_set[j][3], meas[i]);
        rd_chk(base(i) + 14'h0004, ctl_set[j], `MTIS_RESP_OKAY);
        rd_chk(base(i), {5'h00, ctl_set[j][7], ctl_set[j][4], ctl_set[j][7] & ctl_set[j][3]}, 2'h0);
      end
    end
    // a second reset in mid-run returns go to idle
    axi_wr(base(0) + 14'h0004, 8'h80, `MTIS_RESP_OKAY);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_pin("go_rst", 1'b0, go[0]);
    rd_chk(base(0) + 14'h0004, 8'h00, `MTIS_RESP_OKAY);
    finish_test();
  end
endmodule : tb_top
